/* File: core/tco_compare_output.sv */
// Compare output waveform logic of a 16-bit timer with two channels.
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Frequency-correct PWM, non-inverted: compare at BOTTOM stays low, at TOP stays high.
// - Inverted PWM gives the opposite steady levels at BOTTOM and TOP.
// - Mode 9 with channel A mode 01 toggles output A, 50% duty.
// - Single clock with asynchronous reset; timer tick is only a clock enable.
// - Frequency-correct PWM loads active compare values from buffers at BOTTOM.
// - Any nonzero output mode bit makes the channel override its pin.
// - Output mode meaning depends on non-PWM, fast PWM or phase family.
// - Non-PWM: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM 01 toggles A only in modes 14, 15; B disconnected.
// - Fast PWM 10 clears on match and sets at BOTTOM.
// - Fast PWM 11 sets on match and clears at BOTTOM.
// - Fast PWM with compare at TOP ignores the match, keeps BOTTOM action.
// - Phase family 01 toggles A only in modes 9, 11; B disconnected.
// - Phase family 10 clears on up-count match, sets on down-count match.
// - Phase family 11 sets on up-count match, clears on down-count match.
// - Waveform mode joins two control bits here with two upper bits.
module tco_compare_output
  import tco_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_timer_tick,
  input wire logic [15:0] i_count,
  input wire logic i_count_up,
  input wire logic [15:0] i_top,
  input wire logic [1:0] i_waveform_mode_hi,
  output logic o_compare_pin_a,
  output logic o_compare_pin_b,
  output logic o_override_a,
  output logic o_override_b
);

  logic [7:0] ctrl_q;
  logic [15:0] ocr_buf_q [2];
  logic [15:0] ocr_act_q [2];
  logic pin_q [2];
  logic [1:0] com [2];
  logic [3:0] wgm;
  tco_cls_t cls;
  logic pfc;
  logic a_toggle_ok;
  logic upd_act;
  logic at_top;
  logic at_bottom;
  logic wb_req;
  logic ack_q;
  logic wr_en;
  logic [31:0] rd_d;
  logic [31:0] rd_q;

  assign wgm = {i_waveform_mode_hi, ctrl_q[WGM_LO_LSB +: 2]};
  assign com[0] = ctrl_q[COM_A_LSB +: 2];
  assign com[1] = ctrl_q[COM_B_LSB +: 2];
  assign at_top = (i_count == i_top);
  assign at_bottom = (i_count == BOTTOM);

  always_comb begin
    cls = TCO_CLS_OFF;
    pfc = 1'b0;
    a_toggle_ok = 1'b0;
    unique case (wgm)
      WGM_NORMAL, WGM_CTC_OCR, WGM_CTC_ICR: cls = TCO_CLS_NONPWM;
      WGM_FAST8, WGM_FAST9, WGM_FAST10: cls = TCO_CLS_FAST;
      WGM_FAST_ICR, WGM_FAST_OCR: begin
        cls = TCO_CLS_FAST;
        a_toggle_ok = 1'b1;
      end
      WGM_PC8, WGM_PC9, WGM_PC10, WGM_PC_ICR: cls = TCO_CLS_PHASE;
      WGM_PC_OCR: begin
        cls = TCO_CLS_PHASE;
        a_toggle_ok = 1'b1;
      end
      WGM_PFC_ICR: begin
        cls = TCO_CLS_PHASE;
        pfc = 1'b1;
      end
      WGM_PFC_OCR: begin
        cls = TCO_CLS_PHASE;
        pfc = 1'b1;
        a_toggle_ok = 1'b1;
      end
      WGM_RESERVED: cls = TCO_CLS_OFF;
    endcase
  end

  always_comb begin
    unique case (cls)
      TCO_CLS_NONPWM: upd_act = 1'b1;
      TCO_CLS_FAST: upd_act = i_timer_tick & at_bottom;
      TCO_CLS_PHASE: upd_act = i_timer_tick & (pfc ? at_bottom : at_top);
      TCO_CLS_OFF: upd_act = 1'b1;
    endcase
  end

  // Wishbone slave: ack one cycle after the request, write on the ack edge.
  assign wb_req = i_wb_cyc & i_wb_stb;
  assign wr_en = wb_req & i_wb_we & ack_q;
  assign o_wb_ack = ack_q;
  assign o_wb_dat = rd_q;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_req & ~ack_q;
    end
  end

  always_comb begin
    rd_d = RD_ZERO;
    case (i_wb_adr)
      ADR_CTRL_A: rd_d[7:0] = ctrl_q;
      ADR_CMP_A: rd_d[15:0] = ocr_buf_q[0];
      ADR_CMP_B: rd_d[15:0] = ocr_buf_q[1];
      ADR_STATUS: begin
        rd_d[ST_PIN_LSB] = pin_q[0];
        rd_d[ST_PIN_LSB + 1] = pin_q[1];
        rd_d[ST_OVR_LSB] = o_override_a;
        rd_d[ST_OVR_LSB + 1] = o_override_b;
        rd_d[ST_WGM_LSB +: 4] = wgm;
      end
      default: rd_d = RD_ZERO;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rd_q <= RD_ZERO;
    end else if (wb_req && !ack_q) begin
      rd_q <= rd_d;
    end
  end

  // control register with reserved bits forced to zero.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_en && i_wb_adr == ADR_CTRL_A && i_wb_sel[0]) begin
      ctrl_q <= i_wb_dat[7:0] & CTRL_WMASK;
    end
  end

  // pin override when any mode bit is set.
  assign o_override_a = (com[0] != COM_OFF);
  assign o_override_b = (com[1] != COM_OFF);
  assign o_compare_pin_a = pin_q[0];
  assign o_compare_pin_b = pin_q[1];

  for (genvar g = 0; g < 2; g++) begin : g_ch
    localparam logic [7:0] CMP_ADR = (g == 0) ? ADR_CMP_A : ADR_CMP_B;
    logic match;
    logic may_toggle;

    assign match = (i_count == ocr_act_q[g]);
    assign may_toggle = (g == 0) && a_toggle_ok;

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
        ocr_buf_q[g] <= CMP_RST;
      end else if (wr_en && i_wb_adr == CMP_ADR) begin
        if (i_wb_sel[0]) begin
          ocr_buf_q[g][7:0] <= i_wb_dat[7:0];
        end
        if (i_wb_sel[1]) begin
          ocr_buf_q[g][15:8] <= i_wb_dat[15:8];
        end
      end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
        ocr_act_q[g] <= CMP_RST;
      end else if (upd_act) begin
        ocr_act_q[g] <= ocr_buf_q[g];
      end
    end

    // output changes only on a timer tick.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
        pin_q[g] <= 1'b0;
      end else if (i_timer_tick) begin
        unique case (cls)
          TCO_CLS_NONPWM: begin
            if (match && com[g] == COM_TOGGLE) begin
              pin_q[g] <= ~pin_q[g];
            end else if (match && com[g][1]) begin
              pin_q[g] <= com[g][0];
            end
          end
          TCO_CLS_FAST: begin
            if (com[g] == COM_TOGGLE) begin
              if (may_toggle && match) begin
                pin_q[g] <= ~pin_q[g];
              end
            end else if (com[g][1]) begin
              if (match && ocr_act_q[g] != i_top) begin
                pin_q[g] <= com[g][0];
              end else if (at_bottom) begin
                pin_q[g] <= ~com[g][0];
              end
            end
          end
          TCO_CLS_PHASE: begin
            if (com[g] == COM_TOGGLE) begin
              if (may_toggle && match) begin
                pin_q[g] <= ~pin_q[g];
              end
            end else if (com[g][1]) begin
              if (ocr_act_q[g] == BOTTOM) begin
                pin_q[g] <= com[g][0];
              end else if (ocr_act_q[g] == i_top) begin
                pin_q[g] <= ~com[g][0];
              end else if (match) begin
                pin_q[g] <= i_count_up ? com[g][0] : ~com[g][0];
              end
            end
          end
          TCO_CLS_OFF: pin_q[g] <= pin_q[g];
        endcase
      end
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  sequence req_s;
    wb_req && !o_wb_ack;
  endsequence

  sequence tick_a_match_s;
    i_timer_tick && i_count == ocr_act_q[0];
  endsequence

  sequence nonpwm_a_s;
    tick_a_match_s ##0 cls == TCO_CLS_NONPWM;
  endsequence

  bus_ack_a: assert property (req_s |=> o_wb_ack ##1 !o_wb_ack)
    else $error("Bus ack not a single pulse after request.");

  nonpwm_toggle_a: assert property (nonpwm_a_s ##0 com[0] == COM_TOGGLE
    |=> pin_q[0] != $past(pin_q[0])) else $error("Non-PWM toggle missed.");

  nonpwm_clear_a: assert property (nonpwm_a_s ##0 com[0] == COM_CLEAR
    |=> !pin_q[0]) else $error("Non-PWM clear missed.");

  fast_bottom_a: assert property (i_timer_tick && cls == TCO_CLS_FAST
    && com[1] == COM_CLEAR && at_bottom && ocr_act_q[1] != BOTTOM |=> pin_q[1])
    else $error("Fast PWM set at bottom missed.");

  fast_match_set_a: assert property (tick_a_match_s ##0 cls == TCO_CLS_FAST
    && com[0] == COM_SET && ocr_act_q[0] != i_top |=> pin_q[0])
    else $error("Fast PWM inverting set missed.");

  fast_top_skip_a: assert property (tick_a_match_s ##0 cls == TCO_CLS_FAST
    && com[0][1] && at_top && !at_bottom |=> $stable(pin_q[0]))
    else $error("Fast PWM match at top not ignored.");

  fast_b_off_a: assert property (cls == TCO_CLS_FAST
    && com[1] == COM_TOGGLE |=> $stable(pin_q[1]))
    else $error("Fast PWM channel B not disconnected.");

  phase_up_clr_a: assert property (tick_a_match_s ##0 cls == TCO_CLS_PHASE
    && com[0] == COM_CLEAR && i_count_up && !at_bottom && !at_top |=> !pin_q[0])
    else $error("Phase PWM up-count clear missed.");

  pfc_low_a: assert property (i_timer_tick && cls == TCO_CLS_PHASE && pfc
    && com[0] == COM_CLEAR && ocr_act_q[0] == BOTTOM |=> !pin_q[0])
    else $error("Output not low with compare at bottom.");

  inv_top_a: assert property (i_timer_tick && cls == TCO_CLS_PHASE
    && com[1] == COM_SET && ocr_act_q[1] == i_top && i_top != BOTTOM |=> !pin_q[1])
    else $error("Inverted output not low with compare at top.");

  half_duty_a: assert property (tick_a_match_s ##0 wgm == WGM_PFC_OCR
    && com[0] == COM_TOGGLE |=> pin_q[0] != $past(pin_q[0]))
    else $error("Mode 9 toggle missed.");

  pfc_load_a: assert property (i_timer_tick && pfc && at_bottom
    |=> ocr_act_q[0] == $past(ocr_buf_q[0]))
    else $error("Compare value not loaded at bottom.");

  tick_gate_a: assert property (!i_timer_tick
    |=> $stable(pin_q[0]) && $stable(pin_q[1]))
    else $error("Output moved without a timer tick.");

endmodule

`default_nettype wire

/* File: include/tco_pkg.sv */
// Constants and types shared by the compare output block.
package tco_pkg;

  // Byte addresses of the registers on the Wishbone bus.
  localparam logic [7:0] ADR_CTRL_A = 8'h80;
  localparam logic [7:0] ADR_CMP_A = 8'h84;
  localparam logic [7:0] ADR_CMP_B = 8'h88;
  localparam logic [7:0] ADR_STATUS = 8'h8C;

  // Reset values and the writable bits of the control register.
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'hF3;
  localparam logic [15:0] CMP_RST = 16'h0000;
  localparam logic [15:0] BOTTOM = 16'h0000;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  // Field positions in the control and status registers.
  localparam int COM_A_LSB = 6;
  localparam int COM_B_LSB = 4;
  localparam int WGM_LO_LSB = 0;
  localparam int ST_PIN_LSB = 0;
  localparam int ST_OVR_LSB = 2;
  localparam int ST_WGM_LSB = 4;

  // Output mode field codes.
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;

  // Waveform mode codes.
  localparam logic [3:0] WGM_NORMAL = 4'h0;
  localparam logic [3:0] WGM_PC8 = 4'h1;
  localparam logic [3:0] WGM_PC9 = 4'h2;
  localparam logic [3:0] WGM_PC10 = 4'h3;
  localparam logic [3:0] WGM_CTC_OCR = 4'h4;
  localparam logic [3:0] WGM_FAST8 = 4'h5;
  localparam logic [3:0] WGM_FAST9 = 4'h6;
  localparam logic [3:0] WGM_FAST10 = 4'h7;
  localparam logic [3:0] WGM_PFC_ICR = 4'h8;
  localparam logic [3:0] WGM_PFC_OCR = 4'h9;
  localparam logic [3:0] WGM_PC_ICR = 4'hA;
  localparam logic [3:0] WGM_PC_OCR = 4'hB;
  localparam logic [3:0] WGM_CTC_ICR = 4'hC;
  localparam logic [3:0] WGM_RESERVED = 4'hD;
  localparam logic [3:0] WGM_FAST_ICR = 4'hE;
  localparam logic [3:0] WGM_FAST_OCR = 4'hF;

  // Decoding family of the current waveform mode.
  typedef enum logic [1:0] {
    TCO_CLS_OFF = 2'b00,
    TCO_CLS_NONPWM = 2'b01,
    TCO_CLS_FAST = 2'b10,
    TCO_CLS_PHASE = 2'b11
  } tco_cls_t;

endpackage

/* File: tb/tco_testbench.sv */
// Self-checking bench for the compare output block.
`timescale 1ns/100ps
`default_nettype none
module testbench import tco_pkg::*;;
  logic i_clk, i_sys_rst, i_wb_cyc, i_wb_stb, i_wb_we, i_timer_tick, i_count_up;
  logic [7:0] i_wb_adr;
  logic [3:0] i_wb_sel;
  logic [31:0] i_wb_dat, o_wb_dat, rd;
  logic o_wb_ack, o_compare_pin_a, o_compare_pin_b, o_override_a, o_override_b;
  logic pad_dir;
  logic [15:0] i_count, i_top;
  logic [1:0] i_waveform_mode_hi;
  int errors, samples_checked, cycles, w, c, m_ctrl;
  int m_pin[2], m_act[2], m_buf[2];
  int modes[16] = '{13, 0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 14, 15};

  tco_compare_output tco_compare_output_i (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_timer_tick(i_timer_tick),
    .i_count(i_count), .i_count_up(i_count_up), .i_top(i_top),
    .i_waveform_mode_hi(i_waveform_mode_hi), .o_compare_pin_a(o_compare_pin_a),
    .o_compare_pin_b(o_compare_pin_b), .o_override_a(o_override_a),
    .o_override_b(o_override_b)
  );

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // Next pin level of one channel on an acting tick.
  function automatic int nxt(int ch, int w, int c, int cnt, int up, int top, int act, int p);
    int b0 = c % 2;
    if (c == 0)
      return p;
    if (w == 0 || w == 4 || w == 12)
      return (cnt != act) ? p : (c == 1) ? 1 - p : b0;
    if (c == 1)
      return (cnt == act && ch == 0 && (w == 9 || w == 11 || w > 13)) ? 1 - p : p;
    if (w > 4 && w < 8 || w > 13)
      return (cnt == act && act != top) ? b0 : (cnt == 0) ? 1 - b0 : p;
    if (w == 13)
      return p;
    return (act == 0) ? b0 : (act == top) ? 1 - b0 : (cnt == act) ? (up ? b0 : 1 - b0) : p;
  endfunction

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      m_ctrl = 0;
      m_pin = '{0, 0};
      m_act = '{0, 0};
      m_buf = '{0, 0};
    end else begin
      w = i_waveform_mode_hi * 4 + m_ctrl % 4;
      for (int k = 0; k < 2; k++) begin
        c = (m_ctrl >> (6 - 2 * k)) % 4;
        if (i_timer_tick)
          m_pin[k] = nxt(k, w, c, i_count, i_count_up, i_top, m_act[k], m_pin[k]);
        if (w == 0 || w == 4 || w == 12 || w == 13 || i_timer_tick && (i_count == 0 &&
            (w > 4 && w < 10 || w > 13) || i_count == i_top && (w > 0 && w < 4 || w == 10
            || w == 11)))
          m_act[k] = m_buf[k];
      end
      if (i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack) begin
        if (i_wb_adr == ADR_CTRL_A)
          m_ctrl = i_wb_dat[7:0] & CTRL_WMASK;
        if (i_wb_adr == ADR_CMP_A)
          m_buf[0] = i_wb_dat[15:0];
        if (i_wb_adr == ADR_CMP_B)
          m_buf[1] = i_wb_dat[15:0];
      end
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    int n = 0;
    @(posedge i_clk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= we;
    i_wb_adr <= adr;
    i_wb_dat <= wd;
    i_wb_sel <= 4'hF;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 20);
    if (n >= 20)
      errors++;
    rd = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    i_wb_we <= 1'b0;
  endtask

  task automatic step(input int cnt, input logic up, input logic tk);
    @(posedge i_clk);
    i_count <= cnt[15:0];
    i_count_up <= up;
    i_timer_tick <= tk;
    @(negedge i_clk);
    chk("pin_a", o_compare_pin_a, m_pin[0]);
    chk("pin_b", o_compare_pin_b, m_pin[1]);
    chk("pad_a", pad_dir & o_override_a & o_compare_pin_a, pad_dir & (m_ctrl >= 64) & m_pin[0]);
  endtask

  task automatic check_regs();
    wb(1'b0, ADR_CTRL_A, RD_ZERO);
    chk("ctrl", rd, m_ctrl);
    wb(1'b0, ADR_STATUS, RD_ZERO);
    chk("status", rd, (i_waveform_mode_hi * 64 + m_ctrl % 4 * 16) | ((m_ctrl % 64 >= 16) << 3)
        | ((m_ctrl >= 64) << 2) | (m_pin[1] << 1) | m_pin[0]);
    chk("ovr_a", o_override_a, m_ctrl >= 64);
    chk("ovr_b", o_override_b, m_ctrl % 64 >= 16);
    wb(1'b0, ADR_CMP_A, RD_ZERO);
    chk("cmp_a", rd, m_buf[0]);
    wb(1'b0, ADR_CMP_B, RD_ZERO);
    chk("cmp_b", rd, m_buf[1]);
  endtask

  task automatic give_verdict();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge i_clk) begin
    cycles++;
    if (cycles > 12000) begin
      errors++;
      give_verdict();
    end
  end

  initial begin
    {i_wb_cyc, i_wb_stb, i_wb_we, i_timer_tick, i_count_up} = 5'h00;
    {i_wb_adr, i_wb_sel, i_wb_dat, i_count, i_waveform_mode_hi} = 62'h0;
    i_top = 16'h0005;
    // software sets the pin direction to output.
    pad_dir = 1'b1;
    i_sys_rst = 1'b1;
    void'($urandom(32'h9940_1cbd));
    repeat (6) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    check_regs();
    wb(1'b0, 8'h90, 32'h0000_FFFF);
    chk("unmapped", rd, RD_ZERO);
    wb(1'b1, ADR_STATUS, 32'h0000_00FF);
    wb(1'b1, 8'h90, 32'h0000_00FF);
    wb(1'b1, ADR_CTRL_A, 32'h0000_00FF);
    check_regs();
    foreach (modes[i]) begin
      for (int cc = 0; cc < 4; cc++) begin
        wb(1'b1, ADR_CMP_A, (modes[i] inside {4, 9, 11, 15}) ? 5 : (modes[i] == 8) ? 0
            : $urandom % 7);
        wb(1'b1, ADR_CMP_B, (modes[i] == 8) ? 0 : (modes[i] == 10) ? 5 : $urandom % 7);
        wb(1'b1, ADR_CTRL_A, cc * 64 + (3 - cc) * 16 + modes[i] % 4 + $urandom % 4 * 4);
        i_waveform_mode_hi <= 2'(modes[i] / 4);
        repeat (2) begin
          for (int n = 0; n <= 5; n++)
            step(n, 1'b1, 1'b1);
          if (!(modes[i] inside {5, 6, 7, 14, 15}))
            for (int n = 4; n > 0; n--)
              step(n, 1'b0, 1'b1);
        end
        step(0, 1'b0, 1'b0);
        check_regs();
      end
    end
    @(posedge i_clk);
    i_sys_rst <= 1'b1;
    @(posedge i_clk);
    i_sys_rst <= 1'b0;
    check_regs();
    give_verdict();
  end
endmodule
`default_nettype wire
